/* File: verilog/mcs_pkg.sv */
/*
 * mcs_pkg: constants of the core special function register block.
 * assumes: one core clock, synchronous active-high reset.
 */
// Functional notes
// - aux register at 0xF0, reset 0x00, multiply/divide operand and scratch
// - status bit 7 is arithmetic carry and boolean accumulator
// - status bit 6 set on carry out of operand bit 3
// - status bits 4-3 pick one of four register banks in low ram
// - status bit 2 set on arithmetic overflow
// - status bits 5 and 1 are free user flags
// - status bit 0 is odd parity of the accumulator, always
// - parity bit ignores software writes
// - stack pointer at 0x81 resets to 0x07, increments before push/call store
// - stack pointer decrements after pop/return read
// - pointer 0 low 0x82, high 0x83, reset zero, byte or word access
// - second 16-bit pointer at 0x84/0x85 usable like the first
// - select register 0x92 bit 0 picks active pointer, bits 7:1 unused
// - selected pointer supplies the 16-bit indirect address
// - 256-byte scratch ram, upper half indirect only
// - 2048-byte ram decoded at external 0x8000 to 0x87FF
// - cycle control at 0x8E resets 0x01, bits 6-4 program wait states
// - cycle control bits 2-0 set external data stretch, 001 one cycle
package mcs_pkg;
    localparam logic [7:0] ADDR_STACK = 8'h81;
    localparam logic [7:0] ADDR_P0_LO = 8'h82;
    localparam logic [7:0] ADDR_P0_HI = 8'h83;
    localparam logic [7:0] ADDR_P1_LO = 8'h84;
    localparam logic [7:0] ADDR_P1_HI = 8'h85;
    localparam logic [7:0] ADDR_CYCLE = 8'h8e;
    localparam logic [7:0] ADDR_PSEL = 8'h92;
    localparam logic [7:0] ADDR_STATUS = 8'hd0;
    localparam logic [7:0] ADDR_AUX = 8'hf0;

    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] RST_CYCLE = 8'h01;
    localparam logic [7:0] RST_PSEL = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h00;

    localparam int ST_CARRY = 7;
    localparam int ST_HALF = 6;
    localparam int ST_UF0 = 5;
    localparam int ST_BANK_HI = 4;
    localparam int ST_BANK_LO = 3;
    localparam int ST_WRAP = 2;
    localparam int ST_UF1 = 1;
    localparam int ST_PAR = 0;

    localparam int CYC_WAIT_HI = 6;
    localparam int CYC_WAIT_LO = 4;
    localparam int CYC_STR_HI = 2;
    localparam int CYC_STR_LO = 0;
    localparam logic [7:0] CYCLE_WMASK = 8'h77;

    localparam int INTERNAL_SCRATCH_RAM_DEPTH = 256;
    localparam int INTERNAL_SCRATCH_RAM_DIRECT_TOP = 128;
    localparam int XRAM_DEPTH = 2048;
    localparam logic [15:0] XRAM_BASE = 16'h8000;
    localparam logic [15:0] XRAM_LAST = 16'h87ff;

    typedef enum logic [3:0] {
        MCS_STK_IDLE = 4'b0001,
        MCS_STK_PUSH = 4'b0010,
        MCS_STK_POP = 4'b0100,
        MCS_STK_DONE = 4'b1000
    } mcs_stk_t;
endpackage : mcs_pkg

/* File: verilog/mcs_internal_scratch_ram.sv */
/*
 * mcs_internal_scratch_ram: 256-byte internal scratch ram with one port, direct or indirect per access.
 * assumes: one port used per cycle by the core, stack port has priority.
 */
`timescale 1ns/100ps
module mcs_internal_scratch_ram #(
    parameter int DEPTH = mcs_pkg::INTERNAL_SCRATCH_RAM_DEPTH
) (
    input wire logic clk,
    input wire logic [7:0] addr,
    input wire logic indirect,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic refused
);
    if (DEPTH != 256) begin : g_depth_check
        $error("mcs_internal_scratch_ram: depth must be 256");
    end

    logic [7:0] mem [DEPTH];
    logic blocked;

    // direct access may not reach the upper half
    assign blocked = !indirect && (addr >= 8'(mcs_pkg::INTERNAL_SCRATCH_RAM_DIRECT_TOP));
    assign refused = blocked;

    always_ff @(posedge clk) begin
        if (we && !blocked) begin
            mem[addr] <= wdata;
        end
        rdata <= blocked ? 8'h00 : mem[addr];
    end
endmodule : mcs_internal_scratch_ram

/* File: verilog/mcs_xram.sv */
/*
 * mcs_xram: 2048-byte ram in external data space.
 * assumes: 16-bit external address from the selected pointer.
 */
`timescale 1ns/100ps
module mcs_xram #(
    parameter int DEPTH = mcs_pkg::XRAM_DEPTH
) (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic hit
);
    if (DEPTH != 2048) begin : g_depth_check
        $error("mcs_xram: depth must be 2048");
    end

    logic [7:0] mem [DEPTH];

    assign hit = (addr >= mcs_pkg::XRAM_BASE) && (addr <= mcs_pkg::XRAM_LAST);

    always_ff @(posedge clk) begin
        if (we && hit) begin
            mem[addr[10:0]] <= wdata;
        end
        if (re) begin
            rdata <= hit ? mem[addr[10:0]] : 8'h00;
        end
    end
endmodule : mcs_xram

/* File: verilog/mcs_core_regs.sv */
/*
 * mcs_core_regs: core special function registers, stack sequencer,
 * data pointer pair with select, scratch ram and external ram.
 * holds: auxiliary multiply/divide register, status word with bank
 * select and user flags, stack pointer, two 16-bit data pointers,
 * pointer select, memory cycle control, and both ram blocks.
 * assumes: the instruction sequencer gives one-cycle strobes for sfr access,
 * flag updates and stack operations; accumulator lives outside.
 * assumes: sfr read data is taken one cycle after the read strobe and
 * holds until the next read strobe.
 * assumes: stack requests are only raised while no stack operation is
 * in flight; requests in flight are ignored.
 * assumes: the core ram port stays quiet during the one ram cycle of each push or pop;
 * stack accesses take the port and the core request is dropped.
 * assumes: wait-state and stretch fields are acted on by the fetch and
 * external data units; this block only stores and exports them.
 * assumes: the parity flag is pure wiring from acc_value, so a change
 * of the accumulator shows in the status word in the same cycle.
 * assumes: pushes that wrap past 0xff continue at 0x00 in scratch ram.
 * assumes: the external ram answers zero outside its window.
 */
`timescale 1ns/100ps
module mcs_core_regs (
    input wire logic clk,
    input wire logic reset,
    // sfr access
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // accumulator and flag results from the alu
    input wire logic [7:0] acc_value,
    input wire logic alu_flag_we,
    input wire logic alu_carry,
    input wire logic alu_half_carry,
    input wire logic alu_wrap,
    input wire logic bool_carry_we,
    input wire logic bool_carry,
    // multiply/divide result
    input wire logic muldiv_we,
    input wire logic [7:0] muldiv_aux,
    output logic [7:0] aux_mul_reg,
    // stack operations
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [7:0] stack_wdata,
    output logic [7:0] stack_rdata,
    output logic stack_done,
    // 16-bit pointer use
    input wire logic ptr_word_we,
    input wire logic [15:0] ptr_word,
    input wire logic ptr_inc,
    output logic [15:0] ptr_addr,
    // scratch ram access by the core
    input wire logic internal_scratch_ram_req,
    input wire logic internal_scratch_ram_indirect,
    input wire logic internal_scratch_ram_we,
    input wire logic [7:0] internal_scratch_ram_addr,
    input wire logic [7:0] internal_scratch_ram_wdata,
    output logic [7:0] internal_scratch_ram_rdata,
    output logic internal_scratch_ram_refused,
    output logic [7:0] bank_base,
    // external data access through the selected pointer
    input wire logic ext_data_space_we,
    input wire logic ext_data_space_re,
    input wire logic [7:0] ext_data_space_wdata,
    output logic [7:0] ext_data_space_rdata,
    output logic ext_data_space_hit,
    // memory timing to the fetch and external data units, and the status word
    output logic [2:0] prog_wait_states,
    output logic [2:0] ext_data_space_stretch,
    output logic [7:0] proc_status_word
);
    ////////////////////////////////////////////////////////////////////////////////
    // state
    // one record of all registers; the rams keep their own arrays
    // stk is the stack phase, sfr_rdata the held read answer
    typedef struct packed {
        logic [7:0] aux;
        logic [7:0] status;
        logic [7:0] stack;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic psel;
        logic [7:0] cycle;
        mcs_pkg::mcs_stk_t stk;
        logic [7:0] sfr_rdata;
    } mcs_state_t;

    mcs_state_t st_r;
    mcs_state_t st_nxt;

    logic parity;
    logic [7:0] status_view;
    logic [7:0] ram_addr;
    logic ram_indirect;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic ram_refused;

    // parity is pure wiring from the accumulator, never stored
    assign parity = ^acc_value;
    always_comb begin
        status_view = st_r.status;
        status_view[mcs_pkg::ST_PAR] = parity;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.sfr_rdata = st_r.sfr_rdata;

        // software writes
        if (sfr_we) begin
            unique case (sfr_addr)
                mcs_pkg::ADDR_AUX: st_nxt.aux = sfr_wdata;
                // user flags and bank select are plain storage
                mcs_pkg::ADDR_STATUS: st_nxt.status = {sfr_wdata[7:1], 1'b0};
                // software may move the stack pointer at any time;
                // a same-cycle push still wins, see the sequencer below
                mcs_pkg::ADDR_STACK: st_nxt.stack = sfr_wdata;
                mcs_pkg::ADDR_P0_LO: st_nxt.ptr0[7:0] = sfr_wdata;
                mcs_pkg::ADDR_P0_HI: st_nxt.ptr0[15:8] = sfr_wdata;
                mcs_pkg::ADDR_P1_LO: st_nxt.ptr1[7:0] = sfr_wdata;
                mcs_pkg::ADDR_P1_HI: st_nxt.ptr1[15:8] = sfr_wdata;
                mcs_pkg::ADDR_PSEL: st_nxt.psel = sfr_wdata[0];
                // unused bits 7 and 3 hold zero
                mcs_pkg::ADDR_CYCLE: st_nxt.cycle = sfr_wdata & mcs_pkg::CYCLE_WMASK;
                default: ;
            endcase
        end

        // hardware flag updates come after software, so the alu wins a tie
        if (alu_flag_we) begin
            st_nxt.status[mcs_pkg::ST_CARRY] = alu_carry;
            st_nxt.status[mcs_pkg::ST_HALF] = alu_half_carry;
            st_nxt.status[mcs_pkg::ST_WRAP] = alu_wrap;
        end

        // boolean carry lands last, so a bit instruction beats an alu result
        if (bool_carry_we) begin
            st_nxt.status[mcs_pkg::ST_CARRY] = bool_carry;
        end

        // multiply/divide result overrides a software write of aux
        if (muldiv_we) begin
            st_nxt.aux = muldiv_aux;
        end

        // parity is never stored; keep the stored bit at zero
        st_nxt.status[mcs_pkg::ST_PAR] = 1'b0;

        // 16-bit pointer use goes to the selected pointer
        // word load beats increment when both strobes arrive together
        // increments wrap at 16 bits without a carry out
        if (ptr_word_we) begin
            if (st_r.psel) st_nxt.ptr1 = ptr_word;
            else st_nxt.ptr0 = ptr_word;
        end else if (ptr_inc) begin
            if (st_r.psel) st_nxt.ptr1 = st_r.ptr1 + 16'h0001;
            else st_nxt.ptr0 = st_r.ptr0 + 16'h0001;
        end

        // stack sequencer: push stores at the new pointer, pop reads then steps down
        unique case (st_r.stk)
            mcs_pkg::MCS_STK_IDLE: begin
                // push wins when both strobes arrive together
                if (stack_push) begin
                    st_nxt.stack = st_r.stack + 8'h01;
                    st_nxt.stk = mcs_pkg::MCS_STK_PUSH;
                end else if (stack_pop) begin
                    st_nxt.stk = mcs_pkg::MCS_STK_POP;
                end
            end

            mcs_pkg::MCS_STK_PUSH: begin
                // ram write at the already incremented pointer
                st_nxt.stk = mcs_pkg::MCS_STK_DONE;
            end

            mcs_pkg::MCS_STK_POP: begin
                // ram read at the old pointer, step down in the same cycle
                st_nxt.stack = st_r.stack - 8'h01;
                st_nxt.stk = mcs_pkg::MCS_STK_DONE;
            end

            mcs_pkg::MCS_STK_DONE: begin
                // read data of a pop stands in this cycle only
                st_nxt.stk = mcs_pkg::MCS_STK_IDLE;
            end
            // a corrupted phase returns to idle
            default: st_nxt.stk = mcs_pkg::MCS_STK_IDLE;
        endcase

        // registered read data
        // read data holds until the next read strobe
        if (sfr_re) begin
            unique case (sfr_addr)
                mcs_pkg::ADDR_AUX: st_nxt.sfr_rdata = st_r.aux;
                mcs_pkg::ADDR_STATUS: st_nxt.sfr_rdata = status_view;
                mcs_pkg::ADDR_STACK: st_nxt.sfr_rdata = st_r.stack;
                mcs_pkg::ADDR_P0_LO: st_nxt.sfr_rdata = st_r.ptr0[7:0];
                mcs_pkg::ADDR_P0_HI: st_nxt.sfr_rdata = st_r.ptr0[15:8];
                mcs_pkg::ADDR_P1_LO: st_nxt.sfr_rdata = st_r.ptr1[7:0];
                mcs_pkg::ADDR_P1_HI: st_nxt.sfr_rdata = st_r.ptr1[15:8];
                mcs_pkg::ADDR_PSEL: st_nxt.sfr_rdata = {7'h00, st_r.psel};
                mcs_pkg::ADDR_CYCLE: st_nxt.sfr_rdata = st_r.cycle;
                // unmapped addresses read as zero
                default: st_nxt.sfr_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r.aux <= mcs_pkg::RST_AUX;
            st_r.status <= mcs_pkg::RST_STATUS;
            st_r.stack <= mcs_pkg::RST_STACK;
            st_r.ptr0 <= {mcs_pkg::RST_PTR, mcs_pkg::RST_PTR};
            // pointer 1 resets to zero like pointer 0
            st_r.ptr1 <= {mcs_pkg::RST_PTR, mcs_pkg::RST_PTR};
            st_r.psel <= mcs_pkg::RST_PSEL[0];
            st_r.cycle <= mcs_pkg::RST_CYCLE;
            st_r.stk <= mcs_pkg::MCS_STK_IDLE;
            st_r.sfr_rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        unique case (sfr_addr)
            // combinational decode so the sequencer can steer a miss elsewhere
            mcs_pkg::ADDR_AUX, mcs_pkg::ADDR_STATUS, mcs_pkg::ADDR_STACK,
            mcs_pkg::ADDR_P0_LO, mcs_pkg::ADDR_P0_HI, mcs_pkg::ADDR_P1_LO,
            mcs_pkg::ADDR_P1_HI, mcs_pkg::ADDR_PSEL, mcs_pkg::ADDR_CYCLE: sfr_hit = 1'b1;
            default: sfr_hit = 1'b0;
        endcase
    end

    assign sfr_rdata = st_r.sfr_rdata;
    assign aux_mul_reg = st_r.aux;
    assign proc_status_word = status_view;

    assign ptr_addr = st_r.psel ? st_r.ptr1 : st_r.ptr0;
    assign bank_base = {3'b000, st_r.status[mcs_pkg::ST_BANK_HI:mcs_pkg::ST_BANK_LO], 3'b000};

    // wait and stretch codes are exported only; reserved codes are kept
    assign prog_wait_states = st_r.cycle[mcs_pkg::CYC_WAIT_HI:mcs_pkg::CYC_WAIT_LO];
    assign ext_data_space_stretch = st_r.cycle[mcs_pkg::CYC_STR_HI:mcs_pkg::CYC_STR_LO];

    // registered one-cycle pulse, so a pop result is never seen early
    assign stack_done = (st_r.stk == mcs_pkg::MCS_STK_DONE);
    // scratch ram read data is shared by the stack and the core port
    assign stack_rdata = ram_rdata;
    assign internal_scratch_ram_rdata = ram_rdata;
    assign internal_scratch_ram_refused = ram_refused;

    ////////////////////////////////////////////////////////////////////////////////
    // scratch ram: stack cycles take the port, always indirect
    // a core request in a stack cycle is dropped, not queued
    always_comb begin
        ram_addr = internal_scratch_ram_addr;
        ram_indirect = internal_scratch_ram_indirect;
        ram_we = internal_scratch_ram_req && internal_scratch_ram_we;
        ram_wdata = internal_scratch_ram_wdata;
        if (st_r.stk == mcs_pkg::MCS_STK_PUSH) begin
            ram_addr = st_r.stack;
            ram_indirect = 1'b1;
            ram_we = 1'b1;
            ram_wdata = stack_wdata;
        end else if (st_r.stk == mcs_pkg::MCS_STK_POP) begin
            ram_addr = st_r.stack;
            ram_indirect = 1'b1;
            ram_we = 1'b0;
        end
    end

    mcs_internal_scratch_ram #(
        .DEPTH(mcs_pkg::INTERNAL_SCRATCH_RAM_DEPTH)
    ) u_internal_scratch_ram (
        .clk(clk),
        .addr(ram_addr),
        .indirect(ram_indirect),
        .we(ram_we),
        .wdata(ram_wdata),
        .rdata(ram_rdata),
        .refused(ram_refused)
    );

    // external ram addressed by the selected pointer
    // it sees every pointer value and decodes its own window
    mcs_xram #(
        .DEPTH(mcs_pkg::XRAM_DEPTH)
    ) u_xram (
        .clk(clk),
        .addr(ptr_addr),
        .we(ext_data_space_we),
        .re(ext_data_space_re),
        .wdata(ext_data_space_wdata),
        .rdata(ext_data_space_rdata),
        .hit(ext_data_space_hit)
    );
endmodule : mcs_core_regs

/* File: verification/mcs_core_regs_asserts.sv */
/*
 * mcs_core_regs_asserts: port-level checker for the core register block.
 * assumes: bound to mcs_core_regs, one clock, sync active-high reset.
 */
`timescale 1ns/100ps
module mcs_core_regs_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] acc_value,
    input wire logic muldiv_we,
    input wire logic [7:0] muldiv_aux,
    input wire logic [7:0] aux_mul_reg,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic stack_done,
    input wire logic ptr_word_we,
    input wire logic [15:0] ptr_word,
    input wire logic [15:0] ptr_addr,
    input wire logic [7:0] bank_base,
    input wire logic ext_data_space_hit,
    input wire logic [2:0] prog_wait_states,
    input wire logic [2:0] ext_data_space_stretch,
    input wire logic [7:0] proc_status_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // stack sequencer busy shadow: take at c0, idle again at c3
    logic [1:0] busy_r;
    logic [7:0] wd_r;
    always_ff @(posedge clk) begin
        wd_r <= sfr_wdata;
        if (reset) busy_r <= 2'h0;
        else if (busy_r == 2'h0 && (stack_push || stack_pop)) busy_r <= 2'h2;
        else if (busy_r != 2'h0) busy_r <= busy_r - 2'h1;
    end
    sequence stk_take;
        busy_r == 2'h0 && (stack_push || stack_pop);
    endsequence
    sequence stk_answer;
        !stack_done ##1 stack_done ##1 !stack_done;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    aux_load_a: assert property (muldiv_we |=> aux_mul_reg == $past(muldiv_aux))
        else $error("aux register missed multiply result");
    bank_base_a: assert property (bank_base == {3'h0, proc_status_word[4:3], 3'h0})
        else $error("bank base does not follow bank select");
    parity_tracks_acc_a: assert property (proc_status_word[0] == ^acc_value)
        else $error("parity flag wrong");
    stack_answer_a: assert property (stk_take |-> ##1 stk_answer)
        else $error("stack done not two cycles after take");
    sel_read_a: assert property (sfr_re && sfr_addr == 8'h92 |=> sfr_rdata[7:1] == 7'h00)
        else $error("unused select bits read nonzero");
    ptr_word_a: assert property (ptr_word_we && !sfr_we |=> ptr_addr == $past(ptr_word))
        else $error("word load not on pointer address");
    ext_data_space_map_a: assert property (ext_data_space_hit == (ptr_addr >= 16'h8000 && ptr_addr <= 16'h87ff))
        else $error("external ram decode wrong");
    cycle_fields_a: assert property (sfr_we && sfr_addr == 8'h8e |=>
        {prog_wait_states, ext_data_space_stretch} == {wd_r[6:4], wd_r[2:0]})
        else $error("cycle control fields not exported");
endmodule : mcs_core_regs_asserts

bind mcs_core_regs mcs_core_regs_asserts u_chk (.clk, .reset, .sfr_we, .sfr_re, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .acc_value, .muldiv_we, .muldiv_aux, .aux_mul_reg, .stack_push,
    .stack_pop, .stack_done, .ptr_word_we, .ptr_word, .ptr_addr, .bank_base, .ext_data_space_hit,
    .prog_wait_states, .ext_data_space_stretch, .proc_status_word);

/* File: verification/mcs_core_regs_tb.sv */
/*
 * mcs_core_regs_tb: directed bench driving the core register block ports.
 * assumes: checker bound from its own file; 125 MHz clock.
 */
`timescale 1ns/100ps
module mcs_core_regs_tb;
    logic clk = 0, reset = 1, sfr_we = 0, sfr_re = 0, alu_flag_we = 0, alu_carry = 0;
    logic alu_half_carry = 0, alu_wrap = 0, bool_carry_we = 0, bool_carry = 0, muldiv_we = 0;
    logic stack_push = 0, stack_pop = 0, ptr_word_we = 0, ptr_inc = 0, internal_scratch_ram_req = 0;
    logic internal_scratch_ram_indirect = 0, internal_scratch_ram_we = 0, ext_data_space_we = 0, ext_data_space_re = 0;
    logic sfr_hit, stack_done, internal_scratch_ram_refused, ext_data_space_hit;
    logic [7:0] sfr_addr = '0, sfr_wdata = '0, acc_value = '0, muldiv_aux = '0;
    logic [7:0] stack_wdata = '0, internal_scratch_ram_addr = '0, internal_scratch_ram_wdata = '0, ext_data_space_wdata = '0;
    logic [7:0] sfr_rdata, aux_mul_reg, stack_rdata, internal_scratch_ram_rdata, bank_base, ext_data_space_rdata;
    logic [7:0] proc_status_word;
    logic [15:0] ptr_word = '0, ptr_addr;
    logic [2:0] prog_wait_states, ext_data_space_stretch;
    int mismatches = 0, tests_run = 0, cycles = 0;
    logic [7:0] adr [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8e, 8'h92, 8'hd0, 8'hf0};
    logic [7:0] rstv [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] onev [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h77, 8'h01, 8'hfe, 8'hff};

    mcs_core_regs DUT (.clk, .reset, .sfr_we, .sfr_re, .sfr_addr, .sfr_wdata, .sfr_rdata,
        .sfr_hit, .acc_value, .alu_flag_we, .alu_carry, .alu_half_carry, .alu_wrap,
        .bool_carry_we, .bool_carry, .muldiv_we, .muldiv_aux, .aux_mul_reg, .stack_push,
        .stack_pop, .stack_wdata, .stack_rdata, .stack_done, .ptr_word_we, .ptr_word,
        .ptr_inc, .ptr_addr, .internal_scratch_ram_req, .internal_scratch_ram_indirect, .internal_scratch_ram_we, .internal_scratch_ram_addr, .internal_scratch_ram_wdata,
        .internal_scratch_ram_rdata, .internal_scratch_ram_refused, .bank_base, .ext_data_space_we, .ext_data_space_re, .ext_data_space_wdata,
        .ext_data_space_rdata, .ext_data_space_hit, .prog_wait_states, .ext_data_space_stretch, .proc_status_word);

    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_we <= wr;
        sfr_re <= !wr;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_we <= 1'b0;
        sfr_re <= 1'b0;
        #1;
    endtask : sfr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr(1'b0, a, 8'h00);
        check(sfr_rdata, e);
    endtask : rd
    // pointer word load or increment on the selected pointer
    task automatic ptr(input logic ld, input logic [15:0] w);
        @(posedge clk);
        ptr_word_we <= ld;
        ptr_inc <= !ld;
        ptr_word <= w;
        @(posedge clk);
        ptr_word_we <= 1'b0;
        ptr_inc <= 1'b0;
        #1;
    endtask : ptr
    task automatic xd(input logic wr, input logic [7:0] d);
        @(posedge clk);
        ext_data_space_we <= wr;
        ext_data_space_re <= !wr;
        ext_data_space_wdata <= d;
        @(posedge clk);
        ext_data_space_we <= 1'b0;
        ext_data_space_re <= 1'b0;
        #1;
    endtask : xd
    // one push or pop; returns once stack_done is seen, bounded wait
    task automatic stk(input logic push, input logic [7:0] d);
        @(posedge clk);
        stack_push <= push;
        stack_pop <= !push;
        stack_wdata <= d;
        @(posedge clk);
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        for (int i = 0; i < 6 && stack_done !== 1'b1; i++) @(posedge clk) #1;
        check(stack_done, 16'h0001);
    endtask : stk
    task automatic ir(input logic ind, input logic wr, input logic [7:0] a, input logic [7:0] d,
        input logic ref_e, input logic [7:0] e);
        @(posedge clk);
        {internal_scratch_ram_req, internal_scratch_ram_indirect, internal_scratch_ram_we} <= {1'b1, ind, wr};
        internal_scratch_ram_addr <= a;
        internal_scratch_ram_wdata <= d;
        #1 check(internal_scratch_ram_refused, ref_e);
        @(posedge clk);
        internal_scratch_ram_req <= 1'b0;
        #1 if (!wr) check(internal_scratch_ram_rdata, e);
    endtask : ir
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(adr[i], rstv[i]);
            check(sfr_hit, 16'h0001);
        end
        for (int i = 0; i < 9; i++) sfr(1'b1, adr[i], 8'hff);
        for (int i = 0; i < 9; i++) rd(adr[i], onev[i]);
        check({prog_wait_states, ext_data_space_stretch}, 16'h003f);
        sfr(1'b1, 8'h8e, 8'h00);
        check(ext_data_space_stretch, 16'h0000);
        sfr(1'b1, 8'h80, 8'hff);
        rd(8'h80, 8'h00);
        check(sfr_hit, 16'h0000);
        @(posedge clk);
        acc_value <= 8'h07;
        sfr(1'b1, 8'hd0, 8'h00);
        rd(8'hd0, 8'h01);
        @(posedge clk);
        {alu_flag_we, alu_carry, alu_half_carry, alu_wrap} <= 4'hf;
        @(posedge clk);
        alu_flag_we <= 1'b0;
        {bool_carry_we, bool_carry} <= 2'h2;
        #1 check(proc_status_word, 16'h00c5);
        @(posedge clk);
        bool_carry_we <= 1'b0;
        #1 check(proc_status_word, 16'h0045);
        for (int k = 0; k < 4; k++) begin
            sfr(1'b1, 8'hd0, 8'(k << 3));
            check(bank_base, 16'(k * 8));
        end
        sfr(1'b1, 8'h92, 8'h00);
        sfr(1'b1, 8'h82, 8'h34);
        sfr(1'b1, 8'h83, 8'h12);
        check(ptr_addr, 16'h1234);
        sfr(1'b1, 8'h92, 8'h01);
        ptr(1'b1, 16'h8000);
        check(ptr_addr, 16'h8000);
        check(ext_data_space_hit, 16'h0001);
        rd(8'h85, 8'h80);
        xd(1'b1, 8'h5a);
        xd(1'b0, 8'h00);
        check(ext_data_space_rdata, 16'h005a);
        ptr(1'b1, 16'h87ff);
        check(ext_data_space_hit, 16'h0001);
        ptr(1'b0, 16'h0000);
        check(ptr_addr, 16'h8800);
        check(ext_data_space_hit, 16'h0000);
        xd(1'b0, 8'h00);
        check(ext_data_space_rdata, 16'h0000);
        sfr(1'b1, 8'h92, 8'h00);
        check(ptr_addr, 16'h1234);
        ptr(1'b0, 16'h0000);
        check(ptr_addr, 16'h1235);
        rd(8'h82, 8'h35);
        sfr(1'b1, 8'h81, 8'h07);
        stk(1'b1, 8'haa);
        rd(8'h81, 8'h08);
        stk(1'b1, 8'hbb);
        stk(1'b0, 8'h00);
        check(stack_rdata, 16'h00bb);
        rd(8'h81, 8'h08);
        ir(1'b1, 1'b0, 8'h08, 8'h00, 1'b0, 8'haa);
        sfr(1'b1, 8'h81, 8'hff);
        stk(1'b1, 8'hc3);
        rd(8'h81, 8'h00);
        stk(1'b0, 8'h00);
        check(stack_rdata, 16'h00c3);
        rd(8'h81, 8'hff);
        ir(1'b0, 1'b1, 8'h90, 8'h3c, 1'b1, 8'h00);
        ir(1'b1, 1'b1, 8'h90, 8'h3c, 1'b0, 8'h00);
        ir(1'b1, 1'b0, 8'h90, 8'h00, 1'b0, 8'h3c);
        ir(1'b0, 1'b0, 8'h90, 8'h00, 1'b1, 8'h00);
        ir(1'b0, 1'b1, 8'h10, 8'h5a, 1'b0, 8'h00);
        ir(1'b1, 1'b0, 8'h10, 8'h00, 1'b0, 8'h5a);
        @(posedge clk);
        muldiv_we <= 1'b1;
        muldiv_aux <= 8'h96;
        @(posedge clk);
        muldiv_we <= 1'b0;
        rd(8'hf0, 8'h96);
        check(aux_mul_reg, 16'h0096);
        give_verdict();
    end
endmodule : mcs_core_regs_tb
